// file: design/tbpw_pkg.sv
`default_nettype none
package tbpw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00; // enable, invert, output level
  localparam logic [7:0] OFS_DUTY   = 8'h04; // duty high [15:8], low [7:6]
  localparam logic [7:0] OFS_PERIOD = 8'h08; // period limit [7:0]
  localparam logic [7:0] OFS_TIMER  = 8'h0C; // run, prescale, sleep, source
  localparam logic [7:0] OFS_PIN    = 8'h10; // pin direction, latch
  localparam logic [7:0] OFS_COUNT  = 8'h14; // timer count (read only)
  // control register fields
  localparam int CTRL_EN  = 7;
  localparam int CTRL_OUT = 5;
  localparam int CTRL_INV = 4;
  // duty register fields
  localparam int DUTY_HI_LSB = 8;
  localparam int DUTY_LO_LSB = 6;
  // timer register fields
  localparam int TMR_RUN   = 7;
  localparam int TMR_SLEEP = 6;
  localparam int TMR_PS_LSB = 4;
  localparam int TMR_SRC_LSB = 0;
  // pin register fields
  localparam int PIN_DIR   = 0;
  localparam int PIN_LATCH = 1;
  // reset values
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [1:0] SRC_RST    = 2'h1; // second general timer
  localparam logic       DIR_RST    = 1'b1; // input direction
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // prescale selections
  typedef enum logic [1:0] {
    PS_1  = 2'b00,
    PS_4  = 2'b01,
    PS_16 = 2'b10,
    PS_64 = 2'b11
  } tbpw_ps_t;
  localparam logic [5:0] PS_MAX_1  = 6'h00;
  localparam logic [5:0] PS_MAX_4  = 6'h03;
  localparam logic [5:0] PS_MAX_16 = 6'h0F;
  localparam logic [5:0] PS_MAX_64 = 6'h3F;
endpackage
`default_nettype wire

// file: design/tbpw_modulator.sv
// Behaviour
// - time base is 8-bit timer count joined with two low phase bits
// - at prescale 1:1 the two low bits come from the system clock phase
// - output goes active when the selected timer count clears to zero
// - output goes inactive when time base equals buffered 10-bit duty
// - duty at or above period limit never clears the output
// - on period match: count clears, output active, duty copied to shadow
// - zero duty keeps output inactive at period restart
// - duty fields double buffered, writable anytime, used at match only
// - invert bit inverts the output
// - period is (limit+1) times 4 clocks times prescale ratio
// - pulse width is duty times one clock times prescale ratio
// - timer postscaler has no effect on the modulator
// - timer source select field picks the timer, default second timer
// - instances share the timer period, duty is per instance
// - full 10-bit resolution only with period limit 255
// - in sleep timer and modulator freeze, pin holds, resumes after
// - reset returns registers to reset values and pin to input
// - output muxed with latch, reaches pin only when direction is output
// - enable bit switches modulator on and off
// - read-only status bit returns current output level
`default_nettype none
module tbpw_modulator #(
  parameter int NUM_SRC = 4
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // other timers' restart pulses, index 1 is the internal timer
  input  wire logic [NUM_SRC-1:0] extRestart,
  // pin
  output logic             pinOut,
  output logic             pinOe
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic       enable_q;
  logic       invert_q;
  logic [7:0] dutyHigh_q;
  logic [1:0] dutyLow_q;
  logic [7:0] periodLimit_q;
  logic       timerRun_q;
  logic       sleep_q;
  logic [1:0] prescaleSel_q;
  logic [1:0] srcSel_q;
  logic       pinDir_q;
  logic       pinLatch_q;
  logic [7:0] timerCount_q;
  logic [5:0] prescale_q;
  logic [1:0] phase_q;
  logic [9:0] dutyShadow_q;
  logic       pwm_q;
  logic       pwmOut;
  logic       awHeld_q;
  logic [7:0] awAddr_q;
  logic       wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // mapped address check, used by the write response only
  function automatic logic isMapped(input logic [7:0] a);
    if (a == tbpw_pkg::OFS_CTRL) isMapped = 1'b1;
    else if (a == tbpw_pkg::OFS_DUTY) isMapped = 1'b1;
    else if (a == tbpw_pkg::OFS_PERIOD) isMapped = 1'b1;
    else if (a == tbpw_pkg::OFS_TIMER) isMapped = 1'b1;
    else if (a == tbpw_pkg::OFS_PIN) isMapped = 1'b1;
    else if (a == tbpw_pkg::OFS_COUNT) isMapped = 1'b1;
    else isMapped = 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        doWrite;
  logic [7:0]  wAddr;
  logic [31:0] wDat;
  logic [3:0]  wStb;
  assign awready = !awHeld_q && !bvalid_q;
  assign wready  = !wHeld_q && !bvalid_q;
  assign wAddr   = awHeld_q ? awAddr_q : awaddr;
  assign wDat    = wHeld_q ? wData_q : wdata;
  assign wStb    = wHeld_q ? wStrb_q : wstrb;
  assign doWrite = (awHeld_q || (awvalid && awready))
                && (wHeld_q || (wvalid && wready));
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // write channel capture, either order
  always_ff @(posedge mclk) begin
    if (reset || doWrite) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
    end else begin
      if (awvalid && awready) awHeld_q <= 1'b1;
      if (wvalid && wready) wHeld_q <= 1'b1;
    end
  end

  // held write payload
  always_ff @(posedge mclk) begin
    if (reset) begin
      awAddr_q <= 8'h00;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) awAddr_q <= awaddr;
      if (wvalid && wready) begin
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge mclk) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= tbpw_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_q <= 1'b1;
      bresp_q  <= isMapped(wAddr) ? tbpw_pkg::RESP_OKAY
                                  : tbpw_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge mclk) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= tbpw_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= tbpw_pkg::RESP_OKAY;
      rdata_q  <= 32'h00000000;
      if (araddr == tbpw_pkg::OFS_CTRL) begin
        rdata_q[tbpw_pkg::CTRL_EN]  <= enable_q;
        rdata_q[tbpw_pkg::CTRL_OUT] <= pwmOut;
        rdata_q[tbpw_pkg::CTRL_INV] <= invert_q;
      end else if (araddr == tbpw_pkg::OFS_DUTY) begin
        rdata_q[tbpw_pkg::DUTY_HI_LSB +: 8] <= dutyHigh_q;
        rdata_q[tbpw_pkg::DUTY_LO_LSB +: 2] <= dutyLow_q;
      end else if (araddr == tbpw_pkg::OFS_PERIOD) begin
        rdata_q[7:0] <= periodLimit_q;
      end else if (araddr == tbpw_pkg::OFS_TIMER) begin
        rdata_q[tbpw_pkg::TMR_RUN]          <= timerRun_q;
        rdata_q[tbpw_pkg::TMR_SLEEP]        <= sleep_q;
        rdata_q[tbpw_pkg::TMR_PS_LSB +: 2]  <= prescaleSel_q;
        rdata_q[tbpw_pkg::TMR_SRC_LSB +: 2] <= srcSel_q;
      end else if (araddr == tbpw_pkg::OFS_PIN) begin
        rdata_q[tbpw_pkg::PIN_DIR]   <= pinDir_q;
        rdata_q[tbpw_pkg::PIN_LATCH] <= pinLatch_q;
      end else if (araddr == tbpw_pkg::OFS_COUNT) begin
        rdata_q[7:0] <= timerCount_q;
      end else begin
        rresp_q <= tbpw_pkg::RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // reset values
  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_q      <= 1'b0;
      invert_q      <= 1'b0;
      dutyLow_q     <= 2'h0;
      periodLimit_q <= tbpw_pkg::PERIOD_RST;
      timerRun_q    <= 1'b0;
      sleep_q       <= 1'b0;
      prescaleSel_q <= 2'h0;
      srcSel_q      <= tbpw_pkg::SRC_RST;
      pinDir_q      <= tbpw_pkg::DIR_RST;
      pinLatch_q    <= 1'b0;
    end else if (doWrite && wStb[0]) begin
      if (wAddr == tbpw_pkg::OFS_CTRL) begin
        enable_q <= wDat[tbpw_pkg::CTRL_EN];
        invert_q <= wDat[tbpw_pkg::CTRL_INV];
      end else if (wAddr == tbpw_pkg::OFS_DUTY) begin
        dutyLow_q <= wDat[tbpw_pkg::DUTY_LO_LSB +: 2];
      end else if (wAddr == tbpw_pkg::OFS_PERIOD) begin
        periodLimit_q <= wDat[7:0];
      end else if (wAddr == tbpw_pkg::OFS_TIMER) begin
        timerRun_q    <= wDat[tbpw_pkg::TMR_RUN];
        sleep_q       <= wDat[tbpw_pkg::TMR_SLEEP];
        prescaleSel_q <= wDat[tbpw_pkg::TMR_PS_LSB +: 2];
        srcSel_q      <= wDat[tbpw_pkg::TMR_SRC_LSB +: 2];
      end else if (wAddr == tbpw_pkg::OFS_PIN) begin
        pinDir_q   <= wDat[tbpw_pkg::PIN_DIR];
        pinLatch_q <= wDat[tbpw_pkg::PIN_LATCH];
      end
    end
  end

  // duty high byte lives in lane 1
  always_ff @(posedge mclk) begin
    if (reset) begin
      dutyHigh_q <= 8'h00;
    end else if (doWrite && wStb[1] && wAddr == tbpw_pkg::OFS_DUTY) begin
      dutyHigh_q <= wDat[tbpw_pkg::DUTY_HI_LSB +: 8];
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [5:0] psMax;
  logic       psTick;
  logic       periodMatch;
  logic       restart;
  logic       running;
  logic [9:0] timeBase;

  // prescale terminal count
  always_comb begin
    case (tbpw_pkg::tbpw_ps_t'(prescaleSel_q))
      tbpw_pkg::PS_1:  psMax = tbpw_pkg::PS_MAX_1;
      tbpw_pkg::PS_4:  psMax = tbpw_pkg::PS_MAX_4;
      tbpw_pkg::PS_16: psMax = tbpw_pkg::PS_MAX_16;
      default:         psMax = tbpw_pkg::PS_MAX_64;
    endcase
  end

  assign running = timerRun_q && !sleep_q;
  assign psTick  = running && (prescale_q == psMax);
  // increment of the count: four low-bit phases per timer step
  assign periodMatch = timerCount_q == periodLimit_q;
  // source select, internal timer at index 1
  assign restart = (srcSel_q == tbpw_pkg::SRC_RST)
                 ? (psTick && phase_q == 2'h3 && periodMatch)
                 : (!sleep_q && extRestart[srcSel_q]); // frozen in sleep
  // joined time base; low bits from clock phase
  assign timeBase = {timerCount_q, phase_q};

  // prescaler, advances every clock while running, held at zero otherwise (no postscaler used)
  always_ff @(posedge mclk) begin
    if (reset || !running) begin
      prescale_q <= 6'h00;
    end else if (psTick) begin
      prescale_q <= 6'h00;
    end else begin
      prescale_q <= prescale_q + 6'h01;
    end
  end

  // low phase then timer count; no postscaler
  always_ff @(posedge mclk) begin
    if (reset) begin
      phase_q      <= 2'h0;
      timerCount_q <= 8'h00;
    end else if (psTick) begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3) begin
        timerCount_q <= periodMatch ? 8'h00 : timerCount_q + 8'h01;
      end
    end
  end

  // own duty shadow, period limit shared with the timer
  always_ff @(posedge mclk) begin
    if (reset) begin
      dutyShadow_q <= 10'h000;
    end else if (restart) begin
      dutyShadow_q <= {dutyHigh_q, dutyLow_q};
    end
  end

  // ----------------------------------------------------------------
  // output
  // ----------------------------------------------------------------
  logic [9:0] nextDuty;
  logic       dutyFull;
  logic       dutyHit;
  assign nextDuty = {dutyHigh_q, dutyLow_q};
  // duty at or above the limit never clears
  assign dutyFull = dutyShadow_q >= {periodLimit_q, 2'h0};
  // clear as the time base steps onto the duty value
  assign dutyHit  = psTick && (timeBase + 10'h001 == dutyShadow_q)
                 && !dutyFull;

  // set at restart, clear at duty
  always_ff @(posedge mclk) begin
    if (reset || !enable_q) begin
      pwm_q <= 1'b0;
    end else if (restart) begin
      pwm_q <= nextDuty != 10'h000;
    end else if (dutyHit) begin
      pwm_q <= 1'b0;
    end
  end

  assign pwmOut = pwm_q ^ invert_q;

  // pin mux with latch, driven only when direction is output
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      pinOut <= enable_q ? pwmOut : pinLatch_q;
      pinOe  <= !pinDir_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_disabled;
    @(posedge mclk) disable iff (reset) !enable_q |=> !pwm_q;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("output active while disabled");

  property p_restart_set;
    @(posedge mclk) disable iff (reset)
      enable_q && restart && nextDuty != 10'h000 |=> pwm_q;
  endproperty
  a_restart_set: assert property (p_restart_set)
    else $error("output not set at restart");

  property p_zero_duty;
    @(posedge mclk) disable iff (reset)
      restart && nextDuty == 10'h000 |=> !pwm_q;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("zero duty output set");

  property p_shadow;
    @(posedge mclk) disable iff (reset)
      restart |=> dutyShadow_q == $past(nextDuty);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow not loaded");

  property p_shadow_hold;
    @(posedge mclk) disable iff (reset)
      !restart |=> $stable(dutyShadow_q);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("shadow changed off match");

  property p_sleep;
    @(posedge mclk) disable iff (reset)
      sleep_q && $past(sleep_q) |-> $stable(timerCount_q) && $stable(pwm_q);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("state moved in sleep");

  property p_pin_dir;
    @(posedge mclk) disable iff (reset) pinDir_q |=> !pinOe;
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("pin driven while input");

  property p_wrap;
    @(posedge mclk) disable iff (reset)
      psTick && phase_q == 2'h3 && periodMatch |=> timerCount_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count not cleared");

  property p_clear;
    @(posedge mclk) disable iff (reset)
      enable_q && !restart && psTick && !dutyFull
      && (timeBase + 10'h001 == dutyShadow_q) |=> !pwm_q;
  endproperty
  a_clear: assert property (p_clear)
    else $error("output not cleared at duty");

  c_restart: cover property (@(posedge mclk) restart && enable_q);
  c_clear: cover property (@(posedge mclk) pwm_q ##1 !pwm_q);
  c_sleep: cover property (@(posedge mclk) sleep_q && timerRun_q);
endmodule
`default_nettype wire

// file: tb/tbpw_far_side.sv
`default_nettype none
module tbpw_far_side #(
  parameter int NUM_SRC = 4
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // pin as driven by the modulator
  input  wire logic               pinOut,
  input  wire logic               pinOe,
  // level seen at the pin, restarts of other timers
  output logic                    pinLevel,
  output logic [NUM_SRC-1:0]      extRestart
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] divQ;

  // pull-down load: a released pin reads low
  // pin only when output
  assign pinLevel = pinOe ? pinOut : 1'h0;

  // foreign timer restarts every 7 clocks, out of step with ours
  always_ff @(posedge mclk) begin
    if (reset || divQ == 3'h6) begin
      divQ <= 3'h0;
    end else begin
      divQ <= divQ + 3'h1;
    end
  end

  // pulse on index 0 only, index 1 is the internal timer
  assign extRestart = (divQ == 3'h6) ? NUM_SRC'(1) : '0;
endmodule
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pinOut, pinOe, pinLevel;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rd2;
  logic [3:0]  wstrb, extRestart;
  logic [1:0]  bresp, rresp, lastResp;
  int          fail_count, checked, bad;
  int          cycles = 0;

  // --------
  // instances
  // --------
  tbpw_modulator #(.NUM_SRC(4)) u_tbpw_modulator (
    .mclk(mclk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .extRestart(extRestart), .pinOut(pinOut), .pinOe(pinOe));
  tbpw_far_side #(.NUM_SRC(4)) u_tbpw_far_side (
    .mclk(mclk), .reset(reset), .pinOut(pinOut), .pinOe(pinOe),
    .pinLevel(pinLevel), .extRestart(extRestart));

  // 100 ns clock
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // cycle count and hang cut-off
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      complete_run();
    end
  end

  // --------
  // helpers
  // --------
  task automatic complete_run;
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] dutyWord(input logic [9:0] d);
    return {16'h0000, d[9:2], d[1:0], 6'h00};
  endfunction

  // timer always running on the internal source, prescale and sleep as given
  function automatic logic [31:0] tmrWord(input logic [1:0] ps,
                                          input logic slp);
    return {24'h000000, 1'h1, slp, ps, 2'h0, tbpw_pkg::SRC_RST};
  endfunction

  // write address and data offered together, response awaited
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    bit awDone;
    bit wDone;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    awDone = 0;
    wDone = 0;
    while (!(awDone && wDone)) begin
      @(posedge mclk);
      if (!awDone && awvalid && awready) begin
        awDone = 1;
        awvalid <= 1'h0;
      end
      if (!wDone && wvalid && wready) begin
        wDone = 1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'h1);
    lastResp = bresp;
    bready <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge mclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge mclk); while (rvalid !== 1'h1);
    d = rdata;
    lastResp = rresp;
    rready <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic waitLvl(input logic l);
    do @(posedge mclk); while (pinLevel !== l);
  endtask

  // pulse and period measured rise to fall to rise
  task automatic expectPwm(input int eh, input int ep);
    int t0;
    waitLvl(1'h0);
    waitLvl(1'h1);
    t0 = cycles;
    waitLvl(1'h0);
    check(cycles - t0, eh);
    waitLvl(1'h1);
    check(cycles - t0, ep);
  endtask

  task automatic holdLvl(input logic l);
    bad = 0;
    repeat (24) begin
      @(posedge mclk);
      if (pinLevel !== l) bad++;
    end
  endtask

  // --------
  // scenarios
  // --------
  // reset values
  task automatic testReset;
    regRd(tbpw_pkg::OFS_CTRL, rd);
    check(rd, 32'h0);
    regRd(tbpw_pkg::OFS_PERIOD, rd);
    check(rd, {24'h0, tbpw_pkg::PERIOD_RST});
    regRd(tbpw_pkg::OFS_TIMER, rd);
    check(rd, {30'h0, tbpw_pkg::SRC_RST});
    regRd(tbpw_pkg::OFS_PIN, rd);
    check(rd, {31'h0, tbpw_pkg::DIR_RST});
    check(pinOe, 1'h0);
    regRd(8'h18, rd);
    check(lastResp, tbpw_pkg::RESP_SLVERR);
    regWr(8'h18, 32'hFF);
    check(lastResp, tbpw_pkg::RESP_SLVERR);
  endtask

  // setup in the safe order, then first waveform
  task automatic testSetup;
    regWr(tbpw_pkg::OFS_PIN, 32'h1);
    regWr(tbpw_pkg::OFS_CTRL, 32'h0);
    regWr(tbpw_pkg::OFS_PERIOD, 32'h3);
    regWr(tbpw_pkg::OFS_DUTY, dutyWord(10'h6));
    regWr(tbpw_pkg::OFS_TIMER, tmrWord(2'h0, 1'h0));
    repeat (16) @(posedge mclk);
    regWr(tbpw_pkg::OFS_PIN, 32'h0);
    regWr(tbpw_pkg::OFS_CTRL, 32'h80);
    check(pinOe, 1'h1);
    expectPwm(6, 16);
  endtask

  // every prescale ratio, then full resolution
  task automatic testPrescale;
    for (int p = 0; p < 4; p++) begin
      regWr(tbpw_pkg::OFS_TIMER, tmrWord(p[1:0], 1'h0));
      expectPwm(6 << (2 * p), 16 << (2 * p));
    end
    regWr(tbpw_pkg::OFS_TIMER, tmrWord(2'h0, 1'h0));
    regWr(tbpw_pkg::OFS_PERIOD, 32'hFF);
    regWr(tbpw_pkg::OFS_DUTY, dutyWord(10'h3FB));
    expectPwm(1019, 1024);
    regWr(tbpw_pkg::OFS_PERIOD, 32'h3);
    regWr(tbpw_pkg::OFS_DUTY, dutyWord(10'h6));
    regWr(tbpw_pkg::OFS_CTRL, 32'h90);
    expectPwm(10, 16);
    regWr(tbpw_pkg::OFS_CTRL, 32'h80);
  endtask

  // duty written mid-pulse waits for the next restart
  task automatic testBuffer;
    int t0;
    waitLvl(1'h0);
    waitLvl(1'h1);
    t0 = cycles;
    regWr(tbpw_pkg::OFS_DUTY, dutyWord(10'h2));
    waitLvl(1'h0);
    check(cycles - t0, 6);
    expectPwm(2, 16);
  endtask

  // zero and full duty, status bit
  task automatic testExtremes;
    regWr(tbpw_pkg::OFS_DUTY, dutyWord(10'h0));
    repeat (20) @(posedge mclk);
    holdLvl(1'h0);
    check(bad, 0);
    regWr(tbpw_pkg::OFS_DUTY, dutyWord(10'h3FF));
    repeat (20) @(posedge mclk);
    holdLvl(1'h1);
    check(bad, 0);
    regRd(tbpw_pkg::OFS_CTRL, rd);
    check(rd, 32'hA0);
  endtask

  // sleep freezes count and pin, wake resumes
  task automatic testSleep;
    regWr(tbpw_pkg::OFS_DUTY, dutyWord(10'h6));
    regWr(tbpw_pkg::OFS_TIMER, tmrWord(2'h0, 1'h1));
    regRd(tbpw_pkg::OFS_COUNT, rd);
    holdLvl(pinLevel);
    check(bad, 0);
    regRd(tbpw_pkg::OFS_COUNT, rd2);
    check(rd2, rd);
    regWr(tbpw_pkg::OFS_TIMER, tmrWord(2'h0, 1'h0));
    repeat (8) @(posedge mclk);
    regRd(tbpw_pkg::OFS_COUNT, rd);
    check(rd !== rd2, 1);
    expectPwm(6, 16);
  endtask

  // disabled output falls back to the latch
  task automatic testDisable;
    regWr(tbpw_pkg::OFS_CTRL, 32'h0);
    holdLvl(1'h0);
    check(bad, 0);
    regWr(tbpw_pkg::OFS_PIN, 32'h2);
    holdLvl(1'h1);
    check(bad, 0);
    regWr(tbpw_pkg::OFS_PIN, 32'h3);
    @(posedge mclk);
    check(pinOe, 1'h0);
  endtask

  // main sequence
  initial begin
    reset = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    fail_count = 0;
    checked = 0;
    repeat (5) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    testReset();
    testSetup();
    testPrescale();
    testBuffer();
    testExtremes();
    testSleep();
    testDisable();
    complete_run();
  end
endmodule
`default_nettype wire
